// File: cond_block_tracker.sv
`timescale 1ns/100ps
`default_nettype none
`include "exec_state_defines.svh"
module cond_block_tracker
  import exec_state_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic       start,
  input  wire logic [3:0] base_cond,
  input  wire logic [3:0] mask,
  input  wire logic       step,
  input  wire logic       flush,
  output logic [7:0]      state_q
);
  logic [7:0] state_d;
  logic [3:0] next_mask;
  // shift mask left: each bit picks base or inverse condition
  assign next_mask = (state_q[2:0] == 3'h0) ? 4'h0 : {state_q[3:0] << 1};
  always_comb begin
    state_d = state_q;
    if (flush) begin
      state_d = 8'h00;
    end else if (start) begin
      state_d = {base_cond, mask}; // RULE6
    end else if (step && state_q[3:0] != 4'h0) begin
      // low bit of cond tracks the per-slot inversion
      state_d = {state_q[7:5], state_q[4] ^ state_q[3] ^ next_mask[3] ^ state_q[3], next_mask}; // RULE7
      state_d[4] = state_q[3];
      // the fourth slot still runs; the block ends only once the mask empties
      if (next_mask == 4'h0) begin
        state_d = 8'h00;
      end
    end
  end
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_q <= `EXEC_STATE_RESET;
    end else begin
      state_q <= state_d;
    end
  end
  a_cond_upper_kept: assert property (@(posedge clk_sys) disable iff (!rst_n)
    step && !start && !flush && state_q[3:0] != 4'h0 && state_d != 8'h00
    |=> state_q[7:5] == $past(state_q[7:5])) // RULE7
    else $error("base condition changed inside block");
endmodule
`default_nettype wire

// File: exec_state_defines.svh
// Function
// [RULE1] split exec field at 26:25 and 15:10
// [RULE2] resume state keeps 26:25 zero
// [RULE3] resume state keeps 11:10 zero
// [RULE4] interrupt pauses transfer, records next index
// [RULE5] resumed transfer restarts at recorded register
// [RULE6] up to four conditioned instructions per block
// [RULE7] block conditions equal or inverse of base
// [RULE8] set-state bit read-only, resets to one
// [RULE9] exchange branches and pc pop update bit
// [RULE10] exception return reloads bit from stack
// [RULE11] entry or reset loads bit from vector; reset here loads bit 24 of PS_RESET (one), not the vector
// [RULE12] clear state bit faults instead of executing
// [RULE13] split field read-only, resets to zero
// [RULE14] field shown only in combined, exec views
// [RULE15] software preserves reserved bits, ignores value
// [RULE16] saturation flag cleared only by software
// [RULE17] direct exec writes ignored, reads zero
// [RULE18] whole register resets to 0x0100_0000
// [RULE19] reserved bits read zero, ignore writes
`ifndef EXEC_STATE_DEFINES_SVH
`define EXEC_STATE_DEFINES_SVH
`define PS_RESET        32'h0100_0000
`define PS_SAT_BIT      27
`define PS_HI_MSB       26
`define PS_HI_LSB       25
`define PS_SET_BIT      24
`define PS_LO_MSB       15
`define PS_LO_LSB       10
`define PS_IDX_LSB      12
`define EXEC_STATE_RESET 8'h00
`define COND_BLOCK_MAX  3'h4
`endif

// File: exec_state_pkg.sv
package exec_state_pkg;
  typedef enum logic [1:0] {
    VIEW_COMBINED,
    VIEW_EXEC,
    VIEW_APP,
    VIEW_OTHER
  } view_sel_t;
  typedef enum logic [1:0] {
    ES_IDLE,
    ES_RESUME,
    ES_COND
  } es_mode_t;
endpackage

// File: exec_state_status_bits.sv
`timescale 1ns/100ps
`default_nettype none
`include "exec_state_defines.svh"
module exec_state_status_bits
  import exec_state_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // transfer continuation
  input  wire logic        xfer_pause,
  input  wire logic [3:0]  xfer_next_index,
  input  wire logic        xfer_resume_done,
  output logic             xfer_resume_valid,
  output logic [3:0]       xfer_resume_index,
  // conditional block
  input  wire logic        cond_start,
  input  wire logic [3:0]  cond_base,
  input  wire logic [3:0]  cond_mask,
  input  wire logic        cond_step,
  output logic             cond_active,
  output logic [3:0]       cond_current,
  // instruction-set state sources
  input  wire logic        branch_exchange,
  input  wire logic        branch_link_exchange,
  input  wire logic        pop_to_program_counter,
  input  wire logic [31:0] branch_target,
  input  wire logic        exc_return,
  input  wire logic [31:0] stacked_status_word,
  input  wire logic        exc_entry,
  input  wire logic [31:0] vector_value,
  input  wire logic        instr_issue,
  output logic             state_fault,
  // saturation
  input  wire logic        sat_event,
  // software access
  input  wire logic        status_write_instr,
  input  wire logic        status_read_instr,
  input  wire view_sel_t   view_sel,
  input  wire logic [31:0] wr_data,
  output logic [31:0]      rd_data,
  output logic [31:0]      program_status
);
  logic       set_q;
  logic       set_d;
  logic       sat_q;
  logic       sat_d;
  logic [31:0] reset_word;
  logic       fault_q;
  logic [7:0] cond_block_state;
  logic       resume_active;
  logic [3:0] resume_idx;
  logic [7:0] exec_field;
  logic [31:0] exec_view_bits;
  logic [31:0] read_mux;
  wire        app_write;
  wire        show_exec;
  wire        set_src_branch;

  multi_xfer_tracker u_xfer (
    .clk_sys     (clk_sys),
    .rst_n       (rst_n),
    .pause       (xfer_pause),
    .next_index  (xfer_next_index),
    .resume_done (xfer_resume_done),
    .active_q    (resume_active),
    .index_q     (resume_idx)
  );

  cond_block_tracker u_cond (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .start     (cond_start),
    .base_cond (cond_base),
    .mask      (cond_mask),
    .step      (cond_step),
    .flush     (xfer_pause),
    .state_q   (cond_block_state)
  );

  // one field, two meanings; resume state forces the unused bits low
  assign exec_field = resume_active ? {2'b00, resume_idx, 2'b00} // RULE2 RULE3
                                    : cond_block_state;          // RULE1
  assign xfer_resume_valid = resume_active;
  assign xfer_resume_index = resume_idx; // RULE5
  assign cond_active  = !resume_active && cond_block_state[3:0] != 4'h0;
  assign cond_current = cond_block_state[7:4];

  assign set_src_branch = branch_exchange || branch_link_exchange || pop_to_program_counter;
  assign reset_word     = `PS_RESET;

  always_comb begin
    set_d = set_q;
    if (exc_entry) begin
      set_d = vector_value[0]; // RULE11
    end else if (exc_return) begin
      set_d = stacked_status_word[`PS_SET_BIT]; // RULE10
    end else if (set_src_branch) begin
      set_d = branch_target[0]; // RULE9
    end
  end

  // software writes through the app view touch only the saturation flag
  assign app_write = status_write_instr && (view_sel == VIEW_COMBINED || view_sel == VIEW_APP);

  always_comb begin
    sat_d = sat_q;
    if (app_write && !wr_data[`PS_SAT_BIT]) begin
      sat_d = 1'b0; // RULE16
    end
    if (sat_event) begin
      sat_d = 1'b1; // set wins over a same-cycle clear
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      set_q         <= reset_word[`PS_SET_BIT]; // RULE8 RULE18
      sat_q         <= 1'b0;
      fault_q       <= 1'b0;
    end else begin
      set_q         <= set_d; // RULE8
      sat_q         <= sat_d;
      fault_q       <= instr_issue && !set_q; // RULE12
    end
  end
  assign state_fault = fault_q;

  always_comb begin
    exec_view_bits = 32'h0000_0000; // RULE19
    exec_view_bits[`PS_HI_MSB:`PS_HI_LSB] = exec_field[7:6]; // RULE13
    exec_view_bits[`PS_SET_BIT] = set_q;
    exec_view_bits[`PS_LO_MSB:`PS_LO_LSB] = exec_field[5:0];
  end

  assign program_status = exec_view_bits | ({31'h0, sat_q} << `PS_SAT_BIT);

  // direct software reads never expose execution state
  assign show_exec = 1'b0; // RULE17
  always_comb begin
    read_mux = 32'h0000_0000;
    if (view_sel == VIEW_COMBINED || view_sel == VIEW_APP) begin
      read_mux[`PS_SAT_BIT] = sat_q;
    end
    if (show_exec && (view_sel == VIEW_COMBINED || view_sel == VIEW_EXEC)) begin
      read_mux = read_mux | exec_view_bits; // RULE14
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rd_data <= 32'h0000_0000;
    end else if (status_read_instr) begin
      rd_data <= read_mux;
    end
  end

  a_reset_value: assert property (@(posedge clk_sys)
    !rst_n |=> program_status == `PS_RESET) // RULE18
    else $error("status reset value wrong");
  a_resume_zeros: assert property (@(posedge clk_sys) disable iff (!rst_n)
    resume_active |-> program_status[26:25] == 2'b00 && program_status[11:10] == 2'b00) // RULE2
    else $error("resume state upper bits not zero");
  a_resume_index: assert property (@(posedge clk_sys) disable iff (!rst_n)
    xfer_pause |=> program_status[15:12] == $past(xfer_next_index)) // RULE4
    else $error("resume index missing from field");
  a_vector_load: assert property (@(posedge clk_sys) disable iff (!rst_n)
    exc_entry |=> program_status[24] == $past(vector_value[0])) // RULE11
    else $error("state bit not loaded from vector");
  a_return_load: assert property (@(posedge clk_sys) disable iff (!rst_n)
    exc_return && !exc_entry |=> program_status[24] == $past(stacked_status_word[24])) // RULE10
    else $error("state bit not restored on return");
  a_branch_load: assert property (@(posedge clk_sys) disable iff (!rst_n)
    set_src_branch && !exc_entry && !exc_return |=> program_status[24] == $past(branch_target[0])) // RULE9
    else $error("state bit not updated by branch");
  a_sat_sticky: assert property (@(posedge clk_sys) disable iff (!rst_n)
    sat_q && !app_write |=> sat_q) // RULE16
    else $error("saturation flag cleared by hardware");
  a_fault_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
    instr_issue && !program_status[24] |=> state_fault) // RULE12
    else $error("no fault with state bit clear");
  a_read_hidden: assert property (@(posedge clk_sys) disable iff (!rst_n)
    status_read_instr |=> rd_data[26:24] == 3'b000 && rd_data[15:10] == 6'h00) // RULE17
    else $error("exec bits visible to software read");
  a_reserved_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
    program_status[23:16] == 8'h00 && program_status[9:7] == 3'h0) // RULE19
    else $error("reserved bits not zero");

  c_pause: cover property (@(posedge clk_sys) disable iff (!rst_n) xfer_pause ##[1:8] xfer_resume_done);
  c_block: cover property (@(posedge clk_sys) disable iff (!rst_n) cond_start ##1 cond_step[*2]);
  c_fault: cover property (@(posedge clk_sys) disable iff (!rst_n) state_fault);
  c_sat:   cover property (@(posedge clk_sys) disable iff (!rst_n) sat_q ##1 !sat_q);
endmodule
`default_nettype wire

// File: exec_state_status_bits_bench.sv
`timescale 1ns/100ps
`default_nettype none
module exec_state_status_bits_bench;
  import exec_state_pkg::*;
  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  logic        xfer_pause, xfer_resume_done, cond_start, cond_step, branch_exchange;
  logic        branch_link_exchange, pop_to_program_counter, exc_return, exc_entry;
  logic        instr_issue, sat_event, status_write_instr, status_read_instr;
  logic        xfer_resume_valid, cond_active, state_fault;
  logic [3:0]  xfer_next_index, cond_base, cond_mask, xfer_resume_index, cond_current;
  logic [31:0] branch_target, stacked_status_word, vector_value, wr_data, rd_data;
  logic [31:0] program_status;
  view_sel_t   view_sel;
  int          mismatches = 0;
  int          tests_run = 0;

  always #25 clk_sys = ~clk_sys;

  exec_state_status_bits exec_state_status_bits_i (
    .clk_sys(clk_sys), .rst_n(rst_n), .xfer_pause(xfer_pause),
    .xfer_next_index(xfer_next_index), .xfer_resume_done(xfer_resume_done),
    .xfer_resume_valid(xfer_resume_valid), .xfer_resume_index(xfer_resume_index),
    .cond_start(cond_start), .cond_base(cond_base), .cond_mask(cond_mask),
    .cond_step(cond_step), .cond_active(cond_active), .cond_current(cond_current),
    .branch_exchange(branch_exchange), .branch_link_exchange(branch_link_exchange),
    .pop_to_program_counter(pop_to_program_counter), .branch_target(branch_target),
    .exc_return(exc_return), .stacked_status_word(stacked_status_word),
    .exc_entry(exc_entry), .vector_value(vector_value), .instr_issue(instr_issue),
    .state_fault(state_fault), .sat_event(sat_event),
    .status_write_instr(status_write_instr), .status_read_instr(status_read_instr),
    .view_sel(view_sel), .wr_data(wr_data), .rd_data(rd_data),
    .program_status(program_status)
  );

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one-cycle strobe; outputs of the launching edge are settled on return
  task automatic pulse(ref logic s);
    // idle cycle first, so a strobe is never lowered and raised in one step
    @(negedge clk_sys);
    s = 1'b1;
    @(negedge clk_sys);
    s = 1'b0;
  endtask

  task automatic sw_write(input view_sel_t v, input logic [31:0] d);
    view_sel = v;
    wr_data = d;
    pulse(status_write_instr);
  endtask

  task automatic sw_read(input view_sel_t v);
    view_sel = v;
    pulse(status_read_instr);
  endtask

  task automatic tally_and_finish;
    $display("Counts: %0d comparisons, %0d mismatches", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial begin
    #(2000 * 50);
    mismatches++;
    tally_and_finish();
  end

  initial begin
    {xfer_pause, xfer_resume_done, cond_start, cond_step, branch_exchange} = '0;
    {branch_link_exchange, pop_to_program_counter, exc_return, exc_entry} = '0;
    {instr_issue, sat_event, status_write_instr, status_read_instr} = '0;
    {xfer_next_index, cond_base, cond_mask, branch_target, stacked_status_word} = '0;
    {vector_value, wr_data} = '0;
    view_sel = VIEW_COMBINED;
    repeat (5) @(negedge clk_sys);
    rst_n = 1'b1;
    check(program_status, 32'h0100_0000);
    sw_read(VIEW_COMBINED);
    check(rd_data, 32'h0000_0000);
    $display("test reset done");

    xfer_next_index = 4'h5;
    pulse(xfer_pause);
    check(program_status, 32'h0100_5000);
    check({31'h0, xfer_resume_valid}, 32'h0000_0001);
    check({28'h0, xfer_resume_index}, 32'h0000_0005);
    sw_read(VIEW_EXEC);
    check(rd_data, 32'h0000_0000);
    sw_write(VIEW_COMBINED, 32'hf7ff_ffff);
    check(program_status, 32'h0100_5000);
    pulse(xfer_resume_done);
    check({31'h0, xfer_resume_valid}, 32'h0000_0000);
    check(program_status, 32'h0100_0000);
    $display("test resume state done");

    pulse(sat_event);
    check(program_status, 32'h0900_0000);
    sw_read(VIEW_COMBINED);
    check(rd_data, 32'h0800_0000);
    sw_write(VIEW_EXEC, 32'h0000_0000);
    check(program_status, 32'h0900_0000);
    // set and clear in one cycle: the set must win
    sat_event = 1'b1;
    sw_write(VIEW_APP, 32'h0000_0000);
    sat_event = 1'b0;
    check(program_status, 32'h0900_0000);
    sw_write(VIEW_APP, 32'h0000_0000);
    check(program_status, 32'h0100_0000);
    $display("test saturation done");

    cond_base = 4'h0;
    cond_mask = 4'h1;
    pulse(cond_start);
    for (int i = 0; i < 4; i++) begin
      check({31'h0, cond_active}, 32'h0000_0001);
      check({28'h0, cond_current}, 32'h0000_0000);
      pulse(cond_step);
    end
    check({31'h0, cond_active}, 32'h0000_0000);
    cond_mask = 4'hf;
    pulse(cond_start);
    pulse(cond_step);
    check({28'h0, cond_current}, 32'h0000_0001);
    $display("test conditional block done");

    for (int k = 0; k < 3; k++) begin
      branch_target = 32'h0000_0000;
      case (k)
        0: pulse(branch_exchange);
        1: pulse(branch_link_exchange);
        default: pulse(pop_to_program_counter);
      endcase
      check({31'h0, program_status[24]}, 32'h0000_0000);
      pulse(instr_issue);
      check({31'h0, state_fault}, 32'h0000_0001);
      stacked_status_word = 32'h0100_0000;
      pulse(exc_return);
      check({31'h0, program_status[24]}, 32'h0000_0001);
    end
    pulse(instr_issue);
    check({31'h0, state_fault}, 32'h0000_0000);
    vector_value = 32'h0000_0000;
    pulse(exc_entry);
    check({31'h0, program_status[24]}, 32'h0000_0000);
    vector_value = 32'h0000_0001;
    pulse(exc_entry);
    check({31'h0, program_status[24]}, 32'h0000_0001);
    $display("test state bit done");
    tally_and_finish();
  end
endmodule
`default_nettype wire

// File: multi_xfer_tracker.sv
`timescale 1ns/100ps
`default_nettype none
`include "exec_state_defines.svh"
module multi_xfer_tracker (
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic       pause,
  input  wire logic [3:0] next_index,
  input  wire logic       resume_done,
  output logic            active_q,
  output logic [3:0]      index_q
);
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      active_q <= 1'b0;
      index_q  <= 4'h0;
    end else if (pause) begin
      active_q <= 1'b1; // RULE4
      index_q  <= next_index;
    end else if (resume_done) begin
      active_q <= 1'b0;
      index_q  <= 4'h0;
    end
  end
  a_pause_records: assert property (@(posedge clk_sys) disable iff (!rst_n)
    pause |=> active_q && index_q == $past(next_index)) // RULE4
    else $error("paused index not recorded");
endmodule
`default_nettype wire
